// file: design/fsd_top.v
// Feedback sensor decoder: quadrature, analog, pulse width, tachometer, APB registers
// Operation
// - Phase setting negates selected position and velocity for reporting, limits and loop; tach velocity is not negated.
// - Sticky out-of-phase fault when output above 25% and sensor moves opposite.
// - Raw quadrature position and velocity are never inverted.
// - Tachometer velocity takes the sign of the motor output.
// - Quadrature counts every edge of both channels, four per period.
// - Continuous analog mode tracks wraps, position passes 1023 to 1024.
// - Wrap-disable parameter one keeps analog position in 0..1023, no overflow.
// - Pulse timing in 1 us steps, gaps beyond 120 ms mean no pulse.
// - Period reads zero 120 ms after last valid pulse.
// - Report high time and period as integer microseconds.
// - Pulse position 4096 units per rotation, velocity per 100 ms.
// - Pulse decoder resolves 4096 steps per rotation, analog 1024; quadrature counts raw edges.
// - Absolute and relative positions readable and writable together.
// - Quadrature and pulse values decoded and readable whatever source is selected.
// - Output invert reverses motor drive, LED colour stays unchanged.
// - Reset selects quadrature as the feedback source.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "fsd_consts.vh"
module fsd_top #(
  parameter PW_TIMEOUT_CYC = `FSD_PW_TIMEOUT_US * `FSD_CYC_PER_US,
  parameter VEL_WIN_CYC = `FSD_VEL_WIN_US * `FSD_CYC_PER_US
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_quad_a,
  input wire i_quad_b,
  input wire i_pulse_in,
  input wire i_tach_in,
  input wire [9:0] i_adc_value,
  output reg o_motor_drive_neg,
  output reg [6:0] o_motor_drive_mag,
  output reg o_led_green,
  output reg o_led_red,
  output reg o_irq
);
  function [31:0] neg_if;
    input inv;
    input [31:0] v;
    begin
      neg_if = inv ? (32'h0 - v) : v;
    end
  endfunction

  // Two-flop synchronisers for all pins, extra flop for debouncing
  reg [2:0] qa_s, qb_s, pw_s, tc_s;
  reg [9:0] adc_s1, adc_s2;
  reg qa_d, qb_d;
  reg pw_p;
  reg [3:0] us_cnt;
  reg [23:0] win_cnt;
  wire pw_rise = pw_s[2] & ~pw_p;
  // Microsecond grid restarts at each pulse rise, so timings do not jitter by one
  wire us_tick = (us_cnt == `FSD_CYC_PER_US - 1);
  wire win_tick = (win_cnt == VEL_WIN_CYC - 1);
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      qa_s <= 3'h0;
      qb_s <= 3'h0;
      pw_s <= 3'h0;
      tc_s <= 3'h0;
      adc_s1 <= 10'h000;
      adc_s2 <= 10'h000;
      qa_d <= 1'b0;
      qb_d <= 1'b0;
      us_cnt <= 4'h0;
      win_cnt <= 24'h000000;
    end
    else
    begin
      qa_s <= {qa_s[1:0], i_quad_a};
      qb_s <= {qb_s[1:0], i_quad_b};
      pw_s <= {pw_s[1:0], i_pulse_in};
      tc_s <= {tc_s[1:0], i_tach_in};
      adc_s1 <= i_adc_value;
      adc_s2 <= adc_s1;
      // Debounced levels change only when two synced samples agree
      if (qa_s[2] == qa_s[1]) qa_d <= qa_s[2];
      if (qb_s[2] == qb_s[1]) qb_d <= qb_s[2];
      us_cnt <= (us_tick | pw_rise) ? 4'h0 : us_cnt + 4'h1;
      win_cnt <= win_tick ? 24'h000000 : win_cnt + 24'h000001;
    end

  // Control registers
  reg [4:0] ctrl_reg;
  reg [7:0] motor_reg;
  reg [`FSD_ST_W-1:0] status_reg, mask_reg;
  wire [1:0] src = ctrl_reg[`FSD_CTRL_SRC_LSB+1:`FSD_CTRL_SRC_LSB];
  wire phase_inv = ctrl_reg[`FSD_CTRL_PHASE];
  wire wrap_dis = ctrl_reg[`FSD_CTRL_WRAPDIS];
  wire out_inv = ctrl_reg[`FSD_CTRL_OUTINV];
  wire apb_wr = i_psel & i_penable & i_pwrite & o_pready;
  wire apb_rd = i_psel & i_penable & ~i_pwrite & o_pready;
  wire wr_quad = apb_wr & (i_paddr == `FSD_ADDR_QUAD_POS);
  wire wr_pw = apb_wr & (i_paddr == `FSD_ADDR_PW_POS);

  // Quadrature 4x decode
  reg qa_p, qb_p;
  reg [31:0] quad_pos, quad_last, quad_vel;
  wire qa_e = qa_d ^ qa_p;
  wire qb_e = qb_d ^ qb_p;
  // Both channels flipping at once is an illegal jump and is dropped
  wire q_up = (qa_e & ~qb_e & (qa_d != qb_d)) | (qb_e & ~qa_e & (qa_d == qb_d));
  wire q_dn = (qa_e & ~qb_e & (qa_d == qb_d)) | (qb_e & ~qa_e & (qa_d != qb_d));
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      qa_p <= 1'b0;
      qb_p <= 1'b0;
      quad_pos <= 32'h0;
      quad_last <= 32'h0;
      quad_vel <= 32'h0;
    end
    else
    begin
      qa_p <= qa_d;
      qb_p <= qb_d;
      if (wr_quad) quad_pos <= i_pwdata;
      else if (q_up) quad_pos <= quad_pos + 32'h1;
      else if (q_dn) quad_pos <= quad_pos - 32'h1;
      if (win_tick)
      begin
        quad_vel <= quad_pos - quad_last;
        quad_last <= quad_pos;
      end
    end

  // Analog wrap tracking
  reg [9:0] adc_p;
  reg [31:0] an_pos;
  wire [10:0] adc_diff = {1'b0, adc_s2} - {1'b0, adc_p};
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      adc_p <= 10'h000;
      an_pos <= 32'h0;
    end
    else
    begin
      adc_p <= adc_s2;
      if (wrap_dis)
        an_pos <= {22'h0, adc_s2};
      else if (adc_p > adc_s2 && (adc_p - adc_s2) > `FSD_ADC_HALF)
        an_pos <= an_pos + {{21{adc_diff[10]}}, adc_diff} + {22'h0, `FSD_ADC_MAX} + 32'h1;
      else if (adc_s2 > adc_p && (adc_s2 - adc_p) > `FSD_ADC_HALF)
        an_pos <= an_pos + {{21{adc_diff[10]}}, adc_diff} - {22'h0, `FSD_ADC_MAX} - 32'h1;
      else
        an_pos <= an_pos + {{21{adc_diff[10]}}, adc_diff};
    end

  // Pulse width timing; tachometer edge count shares the window in this process
  reg [16:0] pw_run, pw_hi_run;
  reg [16:0] pw_high_us, pw_period_us;
  reg [31:0] pw_pos, pw_last, pw_vel;
  reg pw_valid, pw_new, pw_lost;
  reg tc_p;
  reg [31:0] tach_cnt, tach_vel;
  wire pw_fall = ~pw_s[2] & pw_p;
  wire pw_over = (pw_run >= `FSD_PW_TIMEOUT_US);
  // Tick of the edge cycle itself completes the last microsecond
  wire [16:0] pw_per_now = pw_run + {16'h0, us_tick};
  wire [16:0] pw_hi_now = pw_hi_run + {16'h0, us_tick};
  wire [16:0] pw_den = (pw_per_now == 17'h0) ? 17'h1 : pw_per_now;
  wire [31:0] pw_prod = pw_high_us * `FSD_UNITS_PER_ROT;
  wire [31:0] pw_quot = pw_prod / {15'h0, pw_den};
  wire [11:0] pw_code = pw_quot[11:0];
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      pw_p <= 1'b0;
      pw_run <= 17'h0;
      pw_hi_run <= 17'h0;
      pw_high_us <= 17'h0;
      pw_period_us <= 17'h0;
      pw_pos <= 32'h0;
      pw_last <= 32'h0;
      pw_vel <= 32'h0;
      pw_valid <= 1'b0;
      pw_new <= 1'b0;
      pw_lost <= 1'b0;
      tc_p <= 1'b0;
      tach_cnt <= 32'h0;
      tach_vel <= 32'h0;
    end
    else
    begin
      pw_p <= pw_s[2];
      tc_p <= tc_s[2];
      pw_new <= 1'b0;
      pw_lost <= 1'b0;
      if (us_tick && !pw_over) pw_run <= pw_run + 17'h1;
      if (us_tick && pw_s[2] && !pw_over) pw_hi_run <= pw_hi_run + 17'h1;
      if (pw_fall && !pw_over) pw_high_us <= pw_hi_now;
      if (pw_rise)
      begin
        pw_run <= 17'h0;
        pw_hi_run <= 17'h0;
        if (!pw_over && pw_valid)
        begin
          pw_period_us <= pw_per_now;
          pw_new <= 1'b1;
          if (!wr_pw) pw_pos <= {20'h0, pw_code};
        end
        pw_valid <= 1'b1;
      end
      else if (pw_over && pw_valid)
      begin
        pw_valid <= 1'b0;
        pw_period_us <= 17'h0;
        pw_lost <= 1'b1;
      end
      if (wr_pw) pw_pos <= i_pwdata;
      if (win_tick)
      begin
        pw_vel <= pw_pos - pw_last;
        pw_last <= pw_pos;
        // Tachometer cannot see direction, so it borrows the motor sign
        tach_cnt <= 32'h0;
        tach_vel <= neg_if(motor_reg[7], tach_cnt);
      end
      else if (tc_s[2] & ~tc_p)
        tach_cnt <= tach_cnt + 32'h1;
    end

  // Selected feedback
  reg [31:0] raw_pos, raw_vel, sel_pos, sel_vel, an_last, an_vel;
  always @*
  begin
    case (src)
      `FSD_SRC_ANALOG: raw_pos = an_pos;
      `FSD_SRC_TACH: raw_pos = 32'h0;
      `FSD_SRC_PULSE: raw_pos = pw_pos;
      default: raw_pos = quad_pos;
    endcase
    case (src)
      `FSD_SRC_ANALOG: raw_vel = an_vel;
      `FSD_SRC_TACH: raw_vel = tach_vel;
      `FSD_SRC_PULSE: raw_vel = pw_vel;
      default: raw_vel = quad_vel;
    endcase
  end
  // Tach already carries the motor sign, so phase inversion skips it
  wire [6:0] mag = motor_reg[7] ? (7'h0 - motor_reg[6:0]) : motor_reg[6:0];
  wire over_thr = (mag > `FSD_PHASE_THRESH_PCT);
  wire moving_wrong = (sel_vel != 32'h0) && (sel_vel[31] != motor_reg[7]);
  wire phase_evt = over_thr & moving_wrong & (src != `FSD_SRC_TACH);
  wire [`FSD_ST_W-1:0] evt = {pw_new, pw_lost, phase_evt};
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      sel_pos <= 32'h0;
      sel_vel <= 32'h0;
      an_last <= 32'h0;
      an_vel <= 32'h0;
    end
    else
    begin
      sel_pos <= neg_if(phase_inv, raw_pos);
      sel_vel <= neg_if(phase_inv & (src != `FSD_SRC_TACH), raw_vel);
      if (win_tick)
      begin
        an_vel <= an_pos - an_last;
        an_last <= an_pos;
      end
    end

  // APB slave, zero wait states
  reg [31:0] rd_mux;
  always @*
  begin
    case (i_paddr)
      `FSD_ADDR_CTRL: rd_mux = {27'h0, ctrl_reg};
      `FSD_ADDR_MOTOR: rd_mux = {24'h0, motor_reg};
      `FSD_ADDR_SEL_POS: rd_mux = sel_pos;
      `FSD_ADDR_SEL_VEL: rd_mux = sel_vel;
      `FSD_ADDR_QUAD_POS: rd_mux = quad_pos;
      `FSD_ADDR_QUAD_VEL: rd_mux = quad_vel;
      `FSD_ADDR_AN_POS: rd_mux = an_pos;
      `FSD_ADDR_PW_POS: rd_mux = pw_pos;
      `FSD_ADDR_PW_HIGH: rd_mux = {15'h0, pw_high_us};
      `FSD_ADDR_PW_PER: rd_mux = {15'h0, pw_period_us};
      `FSD_ADDR_PW_VEL: rd_mux = pw_vel;
      `FSD_ADDR_TACH_VEL: rd_mux = tach_vel;
      `FSD_ADDR_STATUS: rd_mux = {29'h0, status_reg};
      `FSD_ADDR_MASK: rd_mux = {29'h0, mask_reg};
      default: rd_mux = 32'h0;
    endcase
  end
  wire mapped = (i_paddr <= `FSD_ADDR_MASK) && (i_paddr[1:0] == 2'h0);
  wire st_rd = apb_rd & (i_paddr == `FSD_ADDR_STATUS);
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      ctrl_reg <= 5'h00;
      motor_reg <= 8'h00;
      status_reg <= 3'h0;
      mask_reg <= 3'h0;
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_motor_drive_neg <= 1'b0;
      o_motor_drive_mag <= 7'h00;
      o_led_green <= 1'b0;
      o_led_red <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      if (i_psel & ~i_penable) o_prdata <= i_pwrite ? 32'h0 : rd_mux;
      if (apb_wr && i_paddr == `FSD_ADDR_CTRL) ctrl_reg <= i_pwdata[4:0];
      if (apb_wr && i_paddr == `FSD_ADDR_MOTOR) motor_reg <= i_pwdata[7:0];
      if (apb_wr && i_paddr == `FSD_ADDR_MASK) mask_reg <= i_pwdata[2:0];
      // Read clears only bits already returned; a new set always wins
      status_reg <= (st_rd ? (status_reg & ~o_prdata[`FSD_ST_W-1:0]) : status_reg) | evt;
      o_motor_drive_neg <= motor_reg[7] ^ out_inv;
      o_motor_drive_mag <= mag;
      o_led_green <= (mag != 7'h00) & ~motor_reg[7];
      o_led_red <= (mag != 7'h00) & motor_reg[7];
      o_irq <= |(status_reg & mask_reg);
    end
endmodule // fsd_top

// file: design/fsd_consts.vh
// Constants for the feedback sensor decoder
`ifndef FSD_CONSTS_VH
`define FSD_CONSTS_VH
`define FSD_CLK_HZ 10000000
`define FSD_US_NS 1000
`define FSD_CLK_NS 100
`define FSD_CYC_PER_US (`FSD_US_NS / `FSD_CLK_NS)
`define FSD_PW_TIMEOUT_MS 120
`define FSD_PW_TIMEOUT_US (`FSD_PW_TIMEOUT_MS * 1000)
`define FSD_VEL_WIN_MS 100
`define FSD_VEL_WIN_US (`FSD_VEL_WIN_MS * 1000)
`define FSD_UNITS_PER_ROT 4096
`define FSD_PHASE_THRESH_PCT 25
`define FSD_ADC_MAX 10'h3FF
`define FSD_ADC_HALF 11'h200
`define FSD_SRC_QUAD 2'h0
`define FSD_SRC_ANALOG 2'h1
`define FSD_SRC_TACH 2'h2
`define FSD_SRC_PULSE 2'h3
`define FSD_ADDR_CTRL 12'h000
`define FSD_ADDR_MOTOR 12'h004
`define FSD_ADDR_SEL_POS 12'h008
`define FSD_ADDR_SEL_VEL 12'h00C
`define FSD_ADDR_QUAD_POS 12'h010
`define FSD_ADDR_QUAD_VEL 12'h014
`define FSD_ADDR_AN_POS 12'h018
`define FSD_ADDR_PW_POS 12'h01C
`define FSD_ADDR_PW_HIGH 12'h020
`define FSD_ADDR_PW_PER 12'h024
`define FSD_ADDR_PW_VEL 12'h028
`define FSD_ADDR_TACH_VEL 12'h02C
`define FSD_ADDR_STATUS 12'h030
`define FSD_ADDR_MASK 12'h034
`define FSD_CTRL_SRC_LSB 0
`define FSD_CTRL_PHASE 2
`define FSD_CTRL_WRAPDIS 3
`define FSD_CTRL_OUTINV 4
`define FSD_ST_PHASE 0
`define FSD_ST_PWLOST 1
`define FSD_ST_PWNEW 2
`define FSD_ST_W 3
`endif

// file: tb/fsd_checker.sv
// Port-level assertions for the feedback sensor decoder
`timescale 1ns/1ps
module fsd_checker (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_motor_drive_neg,
  input wire [6:0] o_motor_drive_mag,
  input wire o_led_green,
  input wire o_led_red,
  input wire o_irq
);
  reg inv_reg;
  reg [1:0] age_reg;
  wire wr_done = i_psel && i_penable && o_pready && i_pwrite;
  // Drive and LEDs settle a few cycles after a control or motor write
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      inv_reg <= 1'b0;
      age_reg <= 2'h0;
    end
    else if (wr_done && i_paddr == 12'h000)
    begin
      inv_reg <= i_pwdata[4];
      age_reg <= 2'h0;
    end
    else if (wr_done && i_paddr == 12'h004)
      age_reg <= 2'h0;
    else if (age_reg != 2'h3)
      age_reg <= age_reg + 2'h1;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  apb_ready_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
  err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  unmapped_err_a: assert property (i_psel && !i_penable && i_paddr > 12'h034 |=> o_pslverr)
    else $error("unmapped access accepted");
  led_excl_a: assert property (!(o_led_green && o_led_red)) else $error("both leds lit");
  led_fwd_a: assert property (age_reg == 2'h3 && o_led_green && o_motor_drive_mag != 7'h0
    |-> o_motor_drive_neg == inv_reg) else $error("forward drive wrong");
  led_rev_a: assert property (age_reg == 2'h3 && o_led_red && o_motor_drive_mag != 7'h0
    |-> o_motor_drive_neg != inv_reg) else $error("reverse drive wrong");
  mag_limit_a: assert property (o_motor_drive_mag <= 7'h64) else $error("drive above full");
  reset_quiet_a: assert property ($fell(i_rst) |-> !o_irq && o_motor_drive_mag == 7'h0)
    else $error("outputs live after reset");
  cover property (o_irq);
  cover property (o_pslverr);
  cover property (o_led_red && o_motor_drive_neg);
endmodule // fsd_checker

// file: tb/fsd_sens.sv
// Sensor-side model: encoder, pulse sensor, tachometer and ADC
`timescale 1ns/1ps
module fsd_sens (
  input wire i_clk,
  output reg o_quad_a,
  output reg o_quad_b,
  output reg o_pulse,
  output reg o_tach,
  output reg [9:0] o_adc
);
  integer ph = 0;
  initial
  begin
    o_quad_a = 1'b0;
    o_quad_b = 1'b0;
    o_pulse = 1'b0;
    o_tach = 1'b0;
    o_adc = 10'h000;
  end
  // Slow steps so the debounce always sees two equal samples
  task quad(input integer n, input logic up);
    integer i;
    for (i = 0; i < 4 * n; i = i + 1)
    begin
      repeat (20) @(posedge i_clk);
      ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
      o_quad_a <= (ph == 1 || ph == 2);
      o_quad_b <= (ph >= 2);
    end
  endtask
  task pulse(input integer hi, input integer per, input integer n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_pulse <= 1'b1;
      repeat (hi * 10) @(posedge i_clk);
      o_pulse <= 1'b0;
      repeat ((per - hi) * 10 - 1) @(posedge i_clk);
    end
  endtask
  task tach(input integer n);
    repeat (n)
    begin
      repeat (5) @(posedge i_clk);
      o_tach <= ~o_tach;
    end
  endtask
  task adc(input logic [9:0] v);
    @(posedge i_clk);
    o_adc <= v;
    repeat (20) @(posedge i_clk);
  endtask
endmodule // fsd_sens

// file: tb/test_feedback_sensor_decoder.sv
// Self-checking bench for the feedback sensor decoder
`timescale 1ns/1ps
module test_feedback_sensor_decoder;
  logic i_sys_clk;
  logic i_rst;
  logic i_psel;
  logic i_penable;
  logic i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_motor_drive_neg, o_led_green, o_led_red, o_irq;
  wire [6:0] o_motor_drive_mag;
  wire i_quad_a, i_quad_b, i_pulse_in, i_tach_in;
  wire [9:0] i_adc_value;
  logic [31:0] rd;
  logic err;
  integer errors = 0;
  integer checks_done = 0;
  initial
  begin
    i_sys_clk = 1'b0;
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
  end
  always #50 i_sys_clk = ~i_sys_clk;
  // Short velocity window keeps the run small
  fsd_top #(.VEL_WIN_CYC(200)) fsd_top_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_quad_a(i_quad_a), .i_quad_b(i_quad_b), .i_pulse_in(i_pulse_in), .i_tach_in(i_tach_in),
    .i_adc_value(i_adc_value), .o_motor_drive_neg(o_motor_drive_neg), .o_motor_drive_mag(o_motor_drive_mag),
    .o_led_green(o_led_green), .o_led_red(o_led_red), .o_irq(o_irq));
  fsd_sens fsd_sens_inst (.i_clk(i_sys_clk), .o_quad_a(i_quad_a), .o_quad_b(i_quad_b),
    .o_pulse(i_pulse_in), .o_tach(i_tach_in), .o_adc(i_adc_value));
  task end_sim;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    // No wait limit here: only the watchdog ends a hung access
    do
    begin
      @(posedge i_sys_clk);
    end
    while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wt(input integer n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  initial
  begin
    // Roughly twice the length of the scenarios
    wt(60000);
    errors++;
    end_sim;
  end
  initial
  begin
    wt(16);
    i_rst <= 1'b0;
    rdc(12'h000, 32'h0);
    fsd_sens_inst.quad(3, 1'b1);
    wt(10);
    rdc(12'h010, 32'hC);
    fsd_sens_inst.quad(1, 1'b0);
    wt(10);
    rdc(12'h010, 32'h8);
    xfer(1'b1, 12'h000, 32'h4);
    rdc(12'h008, 32'hFFFFFFF8);
    rdc(12'h010, 32'h8);
    xfer(1'b1, 12'h010, 32'h64);
    rdc(12'h010, 32'h64);
    rdc(12'h008, 32'hFFFFFF9C);
    xfer(1'b1, 12'h000, 32'h0);
    xfer(1'b1, 12'h034, 32'h1);
    xfer(1'b1, 12'h004, 32'h32);
    fsd_sens_inst.quad(8, 1'b0);
    chk(o_irq, 1'b1);
    xfer(1'b0, 12'h030, 32'h0);
    chk(rd & 32'h1, 32'h1);
    xfer(1'b1, 12'h004, 32'h0);
    // Fault may set again until the motor write lands, so clear once more
    xfer(1'b0, 12'h030, 32'h0);
    xfer(1'b0, 12'h030, 32'h0);
    wt(3);
    chk(rd & 32'h1, 32'h0);
    chk(o_irq, 1'b0);
    xfer(1'b1, 12'h000, 32'h10);
    xfer(1'b1, 12'h004, 32'h32);
    wt(4);
    chk({o_led_green, o_led_red, o_motor_drive_neg, o_motor_drive_mag}, {3'b101, 7'h32});
    xfer(1'b1, 12'h004, 32'hCE);
    wt(4);
    chk({o_led_green, o_led_red, o_motor_drive_neg, o_motor_drive_mag}, {3'b010, 7'h32});
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h000, 32'h1);
    // Steps stay under half scale so only the last one reads as a wrap
    fsd_sens_inst.adc(10'h190);
    fsd_sens_inst.adc(10'h320);
    fsd_sens_inst.adc(10'h3E8);
    fsd_sens_inst.adc(10'h014);
    rdc(12'h018, 32'h414);
    xfer(1'b1, 12'h000, 32'h9);
    fsd_sens_inst.adc(10'h01E);
    rdc(12'h018, 32'h1E);
    fsd_sens_inst.pulse(300, 1000, 3);
    wt(20);
    rdc(12'h020, 32'h12C);
    rdc(12'h024, 32'h3E8);
    rdc(12'h01C, 32'h4CC);
    xfer(1'b1, 12'h000, 32'h2);
    xfer(1'b1, 12'h004, 32'hCE);
    fork
      fsd_sens_inst.tach(80);
      begin
        wt(300);
        xfer(1'b0, 12'h00C, 32'h0);
        chk(rd[31], 1'b1);
      end
    join
    xfer(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    end_sim;
  end
endmodule // test_feedback_sensor_decoder
bind fsd_top fsd_checker fsd_checker_inst (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_motor_drive_neg(o_motor_drive_neg), .o_motor_drive_mag(o_motor_drive_mag),
  .o_led_green(o_led_green), .o_led_red(o_led_red), .o_irq(o_irq));
